// file: dv/servo_power_enable_sequencer_tb_top.sv
`timescale 1ns/1ps
module servo_power_enable_sequencer_tb_top;
	localparam int unsigned DLY = 20;
	localparam spes_pkg::spes_key_t K_ENT = 4'h8;
	localparam spes_pkg::spes_key_t K_LV = 4'h4;
	localparam spes_pkg::spes_key_t K_UP = 4'h2;
	localparam spes_pkg::spes_key_t K_DN = 4'h1;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic main_power_ok = 1'b0;
	logic alarm_active = 1'b0;
	logic servo_enable;
	logic [2:0] control_mode_select;
	spes_pkg::spes_key_t keys;
	logic servo_ready, inverter_on, clockwise, speed_test_active, show_s_mark, in_speed_setting;
	logic signed [15:0] speed_command;
	logic [21:0] exp_q[$];
	event probe;
	event probe_done;
	int n_fail = 0;
	int checks = 0;
	int n;
	// 250 MHz core clock
	always #2 sys_clk = ~sys_clk;
	// Shortened power-up delay keeps the run brief
	spes_sequencer #(.READY_DELAY_CYC(DLY)) spes_sequencer_i (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .main_power_ok(main_power_ok),
		.servo_enable(servo_enable), .alarm_active(alarm_active),
		.control_mode_select(control_mode_select), .keys(keys),
		.servo_ready(servo_ready), .inverter_on(inverter_on),
		.speed_command(speed_command), .clockwise(clockwise),
		.speed_test_active(speed_test_active), .show_s_mark(show_s_mark),
		.in_speed_setting(in_speed_setting)
	);
	spes_panel_model spes_panel_model_i (
		.sys_clk(sys_clk), .servo_enable(servo_enable),
		.control_mode_select(control_mode_select), .keys(keys)
	);
	// All observed outputs in one word
	wire logic [21:0] obs = {servo_ready, inverter_on, speed_test_active, in_speed_setting,
		show_s_mark, clockwise, speed_command};
	function automatic logic [21:0] st(input logic r, input logic i, input logic a,
		input logic s, input logic m, input logic signed [15:0] v);
		return {r, i, a, s, m, (v > 16'sh0000), v};
	endfunction
	task automatic cmp(input logic [21:0] seen, input logic [21:0] want);
		checks++;
		if (seen !== want) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, want);
		end
	endtask
	task automatic chk(input logic [21:0] want);
		exp_q.push_back(want);
		->probe;
		// Hold the driver until the monitor has compared, so new stimulus cannot race it
		@(probe_done);
	endtask
	// Monitor compares every queued note, oldest first, whenever a probe fires
	always @(probe) begin
		while (exp_q.size() > 0)
			cmp(obs, exp_q.pop_front());
		->probe_done;
	end
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask
	task automatic wrap_up();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Bounded wait; a hang counts as a mismatch
	task automatic wait_ready(output int c);
		c = 0;
		while (servo_ready !== 1'b1 && c < 200) begin
			@(posedge sys_clk);
			#1;
			c++;
		end
		if (c >= 200) begin
			n_fail++;
			wrap_up();
		end
	endtask
	// Main sequence: power-up, enable, alarm, speed test-run, modes, power loss
	initial begin
		void'($urandom(32'h1c9117d2));
		repeat (20) @(posedge sys_clk);
		#1;
		sys_rst = 1'b0;
		tick(30);
		chk(22'h000000);
		spes_panel_model_i.set_level(1'b1, spes_pkg::MODE_POSITION);
		tick(5);
		chk(22'h000000);
		main_power_ok = 1'b1;
		wait_ready(n);
		// Ready follows the first edge seeing main power after DLY edges in the wait state
		cmp(22'(n), 22'(DLY + 1));
		chk(st(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'sh0000));
		tick(1);
		chk(st(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 16'sh0000));
		alarm_active = 1'b1;
		#1;
		chk(st(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'sh0000));
		tick(1);
		alarm_active = 1'b0;
		spes_panel_model_i.set_level(1'b0, spes_pkg::MODE_SPEED_TEST);
		tick(2);
		chk(st(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 16'sh0000));
		spes_panel_model_i.press(K_ENT, 1);
		n = 1 + ($urandom % 8);
		spes_panel_model_i.press(K_UP, n);
		tick(1);
		chk(st(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 16'(n)));
		spes_panel_model_i.press(K_DN, 2 * n);
		tick(1);
		chk(st(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, -16'(n)));
		spes_panel_model_i.press(K_LV, 1);
		spes_panel_model_i.press(K_ENT, 1);
		tick(1);
		chk(st(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 16'sh0000));
		spes_panel_model_i.press(K_UP, 3);
		spes_panel_model_i.press(K_DN, 3);
		tick(1);
		chk(st(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 16'sh0000));
		spes_panel_model_i.press(K_UP, 5);
		spes_panel_model_i.press(K_LV, 1);
		chk(st(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 16'sh0005));
		spes_panel_model_i.set_level(1'b0, spes_pkg::MODE_INTERNAL_SPEED);
		tick(2);
		chk(st(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'sh0000));
		// Only modes 4 and 5 energise without enable
		for (int m = 0; m < 7; m++) begin
			spes_panel_model_i.set_level(1'b0, 3'(m));
			tick(2);
			chk(st(1'b1, (m == 4) || (m == 5), m == 4, 1'b0, 1'b0, 16'sh0000));
		end
		spes_panel_model_i.set_level(1'b1, spes_pkg::MODE_POSITION);
		tick(2);
		main_power_ok = 1'b0;
		#1;
		chk(22'h000000);
		tick(3);
		main_power_ok = 1'b1;
		wait_ready(n);
		cmp(22'(n), 22'(DLY + 1));
		// Reset in mid-run clears test-run and restarts the full delay
		spes_panel_model_i.set_level(1'b0, spes_pkg::MODE_SPEED_TEST);
		tick(2);
		sys_rst = 1'b1;
		tick(2);
		chk(22'h000000);
		sys_rst = 1'b0;
		wait_ready(n);
		cmp(22'(n), 22'(DLY + 1));
		chk(st(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'sh0000));
		tick(1);
		chk(st(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 16'sh0000));
		wrap_up();
	end
endmodule

// file: dv/spes_panel_model.sv
`timescale 1ns/1ps
// Host enable level, mode setting and keypad events facing the sequencer
module spes_panel_model (
	input wire logic sys_clk,
	output logic servo_enable,
	output logic [2:0] control_mode_select,
	output spes_pkg::spes_key_t keys
);
	// Everything idles low so nothing is requested before the bench asks
	initial begin
		servo_enable = 1'b0;
		control_mode_select = 3'h0;
		keys = '0;
	end
	// One-cycle key events with an idle cycle between, as a real keypad
	task automatic press(input spes_pkg::spes_key_t k, input int unsigned cnt);
		for (int unsigned i = 0; i < cnt; i++) begin
			keys = k;
			@(posedge sys_clk);
			#1;
			keys = '0;
			@(posedge sys_clk);
			#1;
		end
	endtask
	// Levels change only just after an edge
	task automatic set_level(input logic en, input logic [2:0] mode);
		servo_enable = en;
		control_mode_select = mode;
	endtask
endmodule

// file: src/spes_pkg.sv
package spes_pkg;
	// Core clock rate
	localparam int unsigned CLK_HZ = 250000000;
	// Power-up delay after main power appears
	localparam int unsigned READY_DELAY_MS = 1500;
	localparam longint unsigned READY_DELAY_CYC_L = longint'(CLK_HZ) * READY_DELAY_MS / 1000;
	localparam int unsigned READY_DELAY_CYC = int'(READY_DELAY_CYC_L);
	localparam int unsigned CNT_W = 32;

	// Control mode encoding
	localparam logic [2:0] MODE_POSITION = 3'h0;
	localparam logic [2:0] MODE_ANALOG_SPEED = 3'h1;
	localparam logic [2:0] MODE_TORQUE = 3'h2;
	localparam logic [2:0] MODE_INTERNAL_SPEED = 3'h3;
	localparam logic [2:0] MODE_SPEED_TEST = 3'h4;
	localparam logic [2:0] MODE_JOG_TEST = 3'h5;
	localparam logic [2:0] MODE_FACTORY = 3'h6;

	// Speed setpoint in r/min, signed
	localparam int unsigned SPD_W = 16;
	localparam logic signed [SPD_W-1:0] SPD_ZERO = 16'sh0000;
	localparam logic signed [SPD_W-1:0] SPD_STEP = 16'sh0001;
	localparam logic signed [SPD_W-1:0] SPD_MAX = 16'sh1770;
	localparam logic signed [SPD_W-1:0] SPD_MIN = -16'sh1770;

	// Sequencer states
	typedef enum logic [1:0] {
		SPES_OFF = 2'b00,
		SPES_WAIT = 2'b01,
		SPES_READY = 2'b10
	} spes_state_t;

	// Keypad events for the test-speed setting
	typedef struct packed {
		logic enter;
		logic leave;
		logic up;
		logic down;
	} spes_key_t;

	// Drive command towards the inverter
	typedef struct packed {
		logic inverter_on;
		logic signed [SPD_W-1:0] speed;
		logic speed_test_active;
	} spes_drive_t;
endpackage

// file: src/spes_sequencer.sv
`timescale 1ns/1ps
module spes_sequencer #(
	parameter int unsigned READY_DELAY_CYC = spes_pkg::READY_DELAY_CYC
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic main_power_ok,
	input wire logic servo_enable,
	input wire logic alarm_active,
	input wire logic [2:0] control_mode_select,
	input wire spes_pkg::spes_key_t keys,
	output logic servo_ready,
	output logic inverter_on,
	output logic signed [spes_pkg::SPD_W-1:0] speed_command,
	output logic clockwise,
	output logic speed_test_active,
	output logic show_s_mark,
	output logic in_speed_setting
);
	spes_pkg::spes_state_t state;
	spes_pkg::spes_state_t next_state;
	logic [spes_pkg::CNT_W-1:0] cnt;
	logic [spes_pkg::CNT_W-1:0] next_cnt;
	logic [2:0] mode_q;
	logic mode_changed;
	logic test_mode;
	logic next_inverter_on;
	logic signed [spes_pkg::SPD_W-1:0] next_speed_command;
	logic signed [spes_pkg::SPD_W-1:0] test_speed_setpoint;
	spes_pkg::spes_drive_t drv;

	// Mode decode; jog shares the no-external-signal behaviour
	assign test_mode = control_mode_select == spes_pkg::MODE_SPEED_TEST
		|| control_mode_select == spes_pkg::MODE_JOG_TEST;
	assign mode_changed = speed_test_active && control_mode_select != mode_q;

	// Power-up sequencer; counting from zero gives a fixed, repeatable delay
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		case (state)
			spes_pkg::SPES_OFF: begin
				next_cnt = '0;
				if (main_power_ok) begin
					next_state = spes_pkg::SPES_WAIT;
				end
			end
			spes_pkg::SPES_WAIT: begin
				if (cnt >= READY_DELAY_CYC - 1) begin
					next_state = spes_pkg::SPES_READY;
				end else begin
					next_cnt = cnt + 1'b1;
				end
			end
			spes_pkg::SPES_READY: begin
				next_cnt = '0;
			end
			default: begin
				next_state = spes_pkg::SPES_OFF;
				next_cnt = '0;
			end
		endcase
		if (!main_power_ok) begin
			next_state = spes_pkg::SPES_OFF;
			next_cnt = '0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state <= spes_pkg::SPES_OFF;
			cnt <= '0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end

	// Ready drops combinationally with main power so there is no lag cycle
	assign servo_ready = state == spes_pkg::SPES_READY && main_power_ok;

	spes_speed_test spes_speed_test_i (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.active(speed_test_active),
		.mode_changed(mode_changed),
		.keys(keys),
		.test_speed_setpoint(test_speed_setpoint),
		.in_setting(in_speed_setting),
		.show_s_mark(show_s_mark)
	);

	// Drive decision; alarm always wins so the motor coasts
	always_comb begin
		drv.speed_test_active = control_mode_select == spes_pkg::MODE_SPEED_TEST
			&& servo_ready && !alarm_active;
		drv.inverter_on = 1'b0;
		drv.speed = spes_pkg::SPD_ZERO;
		if (servo_ready && !alarm_active) begin
			if (test_mode) begin
				drv.inverter_on = 1'b1;
			end else begin
				drv.inverter_on = servo_enable;
			end
		end
		if (drv.speed_test_active && !mode_changed) begin
			drv.speed = test_speed_setpoint;
		end
		next_inverter_on = drv.inverter_on;
		next_speed_command = drv.speed;
	end

	// Inverter and command are registered; main loss and alarm also gate the inverter combinationally
	logic inverter_q;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			inverter_q <= 1'b0;
			speed_command <= spes_pkg::SPD_ZERO;
			speed_test_active <= 1'b0;
			mode_q <= spes_pkg::MODE_POSITION;
		end else begin
			inverter_q <= next_inverter_on;
			speed_command <= next_speed_command;
			speed_test_active <= drv.speed_test_active;
			mode_q <= control_mode_select;
		end
	end

	assign inverter_on = inverter_q && main_power_ok && !alarm_active;
	assign clockwise = speed_command > spes_pkg::SPD_ZERO;

	property p_no_ready_without_main;
		@(posedge sys_clk) disable iff (sys_rst)
		!main_power_ok |-> !servo_ready && !inverter_on;
	endproperty
	a_no_ready_without_main: assert property (p_no_ready_without_main) else $error("ready without main");

	property p_ready_rise;
		@(posedge sys_clk) disable iff (sys_rst)
		$rose(servo_ready) |-> $past(state) == spes_pkg::SPES_WAIT
			&& $past(cnt) == READY_DELAY_CYC - 1;
	endproperty
	a_ready_rise: assert property (p_ready_rise) else $error("ready rose early");

	property p_enable_on;
		@(posedge sys_clk) disable iff (sys_rst)
		(servo_ready && servo_enable && !alarm_active && !test_mode) ##1
			(main_power_ok && !alarm_active) |-> inverter_on;
	endproperty
	a_enable_on: assert property (p_enable_on) else $error("enable ignored");

	property p_alarm_off;
		@(posedge sys_clk) disable iff (sys_rst)
		alarm_active |-> !inverter_on;
	endproperty
	a_alarm_off: assert property (p_alarm_off) else $error("inverter on in alarm");

	property p_on_needs_ready;
		@(posedge sys_clk) disable iff (sys_rst)
		$rose(inverter_on) |-> $past(servo_ready);
	endproperty
	a_on_needs_ready: assert property (p_on_needs_ready) else $error("inverter on before ready");

	property p_test_no_enable;
		@(posedge sys_clk) disable iff (sys_rst)
		(servo_ready && test_mode && !alarm_active) ##1 (main_power_ok && !alarm_active)
			|-> inverter_on;
	endproperty
	a_test_no_enable: assert property (p_test_no_enable) else $error("test mode not driving");

	property p_speed_zero_stop;
		@(posedge sys_clk) disable iff (sys_rst)
		(speed_test_active && !mode_changed && test_speed_setpoint == spes_pkg::SPD_ZERO
			&& control_mode_select == spes_pkg::MODE_SPEED_TEST && servo_ready
			&& !alarm_active) |=> speed_command == spes_pkg::SPD_ZERO && speed_test_active;
	endproperty
	a_speed_zero_stop: assert property (p_speed_zero_stop) else $error("zero setpoint moved");

	property p_main_loss;
		@(posedge sys_clk) disable iff (sys_rst)
		$fell(main_power_ok) |=> state == spes_pkg::SPES_OFF && cnt == '0;
	endproperty
	a_main_loss: assert property (p_main_loss) else $error("delay not restarted");

	// Mode 4 with ready and no alarm must enter speed test-run on the next edge
	property p_test_run_entry;
		@(posedge sys_clk) disable iff (sys_rst)
		(control_mode_select == spes_pkg::MODE_SPEED_TEST && servo_ready && !alarm_active)
			|=> speed_test_active;
	endproperty
	a_test_run_entry: assert property (p_test_run_entry) else $error("test-run not entered");

	property p_other_mode_idle;
		@(posedge sys_clk) disable iff (sys_rst)
		control_mode_select != spes_pkg::MODE_SPEED_TEST |=> !speed_test_active;
	endproperty
	a_other_mode_idle: assert property (p_other_mode_idle) else $error("test-run in other mode");

	// The command lags the keypad setpoint by exactly one edge
	property p_speed_follows;
		@(posedge sys_clk) disable iff (sys_rst)
		(speed_test_active && !mode_changed && control_mode_select == spes_pkg::MODE_SPEED_TEST
			&& servo_ready && !alarm_active) |=> speed_command == $past(test_speed_setpoint);
	endproperty
	a_speed_follows: assert property (p_speed_follows) else $error("command not at setpoint");

	property p_mode_change_speed;
		@(posedge sys_clk) disable iff (sys_rst)
		mode_changed |=> speed_command == spes_pkg::SPD_ZERO;
	endproperty
	a_mode_change_speed: assert property (p_mode_change_speed) else $error("mode change moved");

	// Enable held through power-up must not reach the inverter before ready
	property p_off_before_ready;
		@(posedge sys_clk) disable iff (sys_rst)
		!servo_ready |=> !inverter_on;
	endproperty
	a_off_before_ready: assert property (p_off_before_ready) else $error("inverter before ready");
endmodule

// file: src/spes_speed_test.sv
`timescale 1ns/1ps
module spes_speed_test (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic active,
	input wire logic mode_changed,
	input wire spes_pkg::spes_key_t keys,
	output logic signed [spes_pkg::SPD_W-1:0] test_speed_setpoint,
	output logic in_setting,
	output logic show_s_mark
);
	logic signed [spes_pkg::SPD_W-1:0] next_test_speed_setpoint;
	logic next_in_setting;

	// Step the setpoint with saturation at the speed limits
	function automatic logic signed [spes_pkg::SPD_W-1:0] step_spd(
		input logic signed [spes_pkg::SPD_W-1:0] v,
		input logic up
	);
		logic signed [spes_pkg::SPD_W-1:0] r;
		r = v;
		if (up && v < spes_pkg::SPD_MAX) begin
			r = v + spes_pkg::SPD_STEP;
		end else if (!up && v > spes_pkg::SPD_MIN) begin
			r = v - spes_pkg::SPD_STEP;
		end
		return r;
	endfunction

	// Setpoint updates; deactivation and mode change force zero so motor stops, leave keeps the setpoint
	always_comb begin
		next_test_speed_setpoint = test_speed_setpoint;
		next_in_setting = in_setting;
		if (!active || mode_changed) begin
			next_test_speed_setpoint = spes_pkg::SPD_ZERO;
			next_in_setting = 1'b0;
		end else if (keys.enter && !in_setting) begin
			next_test_speed_setpoint = spes_pkg::SPD_ZERO;
			next_in_setting = 1'b1;
		end else if (keys.leave) begin
			next_in_setting = 1'b0;
		end else if (in_setting && keys.up && !keys.down) begin
			next_test_speed_setpoint = step_spd(test_speed_setpoint, 1'b1);
		end else if (in_setting && keys.down && !keys.up) begin
			next_test_speed_setpoint = step_spd(test_speed_setpoint, 1'b0);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			test_speed_setpoint <= spes_pkg::SPD_ZERO;
			in_setting <= 1'b0;
		end else begin
			test_speed_setpoint <= next_test_speed_setpoint;
			in_setting <= next_in_setting;
		end
	end

	// Positive value shown with leading S
	assign show_s_mark = test_speed_setpoint > spes_pkg::SPD_ZERO;

	property p_reenter_clears;
		@(posedge sys_clk) disable iff (sys_rst)
		(active && !mode_changed && keys.enter && !in_setting)
			|=> (test_speed_setpoint == spes_pkg::SPD_ZERO && in_setting);
	endproperty
	a_reenter_clears: assert property (p_reenter_clears) else $error("reentry kept old setpoint");

	property p_mode_change_stop;
		@(posedge sys_clk) disable iff (sys_rst)
		mode_changed |=> test_speed_setpoint == spes_pkg::SPD_ZERO;
	endproperty
	a_mode_change_stop: assert property (p_mode_change_stop) else $error("mode change kept speed");
endmodule
